// >>> verilog/sec_pkg.sv
// package for the serial eeprom command engine: sizes, opcodes, timing, carriers
// assumes one 50 MHz system clock; the serial pins are sampled on that clock
package sec_pkg;

   // storage and organisation
   localparam int WORD_W = 16;
   localparam int BYTE_W = 8;
   localparam int WORDS = 512;
   localparam int BYTES = 1024;
   localparam int WADDR_W = 9;
   localparam int BADDR_W = 10;
   localparam int TOTAL_BITS = WORDS * WORD_W;

   // frame lengths after the start bit
   localparam int OPC_BITS = 2;
   localparam int ADDR_BITS_X16 = 10;
   localparam int ADDR_BITS_X8 = 11;
   localparam int HDR_W = OPC_BITS + ADDR_BITS_X8;
   localparam logic [3:0] HDR_LAST_X16 = 4'hb;
   localparam logic [3:0] HDR_LAST_X8 = 4'hc;
   localparam logic [3:0] DATA_LAST_X16 = 4'hf;
   localparam logic [3:0] DATA_LAST_X8 = 4'h7;

   // opcodes and special selectors
   localparam logic [1:0] OPC_READ = 2'h2;
   localparam logic [1:0] OPC_ERASE = 2'h3;
   localparam logic [1:0] OPC_WRITE = 2'h1;
   localparam logic [1:0] OPC_SPECIAL = 2'h0;
   localparam logic [1:0] SEL_UNLOCK = 2'h3;
   localparam logic [1:0] SEL_LOCK = 2'h0;
   localparam logic [1:0] SEL_CLEAR_ALL = 2'h2;
   localparam logic [1:0] SEL_FILL_ALL = 2'h1;

   localparam logic [WORD_W-1:0] ERASED_WORD = 16'hffff;
   localparam logic [BYTE_W-1:0] ERASED_BYTE = 8'hff;

   // timing
   localparam int CLK_FREQ_MHZ = 50;
   localparam int PROG_TIME_US = 5000;
   localparam int PROG_CYCLES_DEF = PROG_TIME_US * CLK_FREQ_MHZ;
   localparam int FIFO_DEPTH_DEF = 16;

   typedef enum logic [1:0]
   {
      OP_WRITE = 2'b00,
      OP_ERASE = 2'b01,
      OP_CLEAR_ALL = 2'b10,
      OP_FILL_ALL = 2'b11
   } sec_op_t;

   // pending programming operation, held from decode to the end of the cycle
   typedef struct packed
   {
      sec_op_t op;
      logic [BADDR_W-1:0] addr;
      logic [WORD_W-1:0] data;
   } sec_prog_t;

endpackage

// >>> verilog/sec_engine.sv
// serial eeprom command engine: framing, decode, sequential read, self-timed programming
// assumes CHIP_SELECT, SERIAL_CLOCK and SERIAL_IN are synchronous to CLK and that
// SERIAL_CLOCK highs and lows each last several CLK periods
//
// What this block does
// - Holds 8192 bits as 1024 bytes or 512 sixteen-bit words.
// - Frame is start bit one, two-bit opcode, then 10 or 11 address bits.
// - Word mode: 10 read, 11 erase, 01 write, 00 special; 13-bit frame.
// - Byte mode: same opcodes, 11-bit address, 14-bit frame, 8-bit write data.
// - Opcode 00: top address bits pick unlock, lock, clear-all or fill-all.
// - Command, address and data bits sampled on serial clock rising edges.
// - Output floats except during read data or ready/busy reporting.
// - With chip select high after programming, output low busy, high ready.
// - A one clocked in while status shows floats output at next falling edge.
// - Read drives one zero bit, then the word MSB first, on rising edges.
// - Continued clocking reads the next word, wrapping from last address to zero.
// - Only the first word of a sequential read has the leading zero.
// - Write starts on chip select fall: clear then store, no prior erase needed.
// - Erase on chip select fall sets every bit of the location to one.
// - Clear-all on chip select fall sets every memory bit to one.
// - Fill-all programs its data word into every location, self-timed.
// - Powers up locked; writes ignored until unlock, which lasts until lock.
// - Reads work normally whether locked or unlocked.
// - Held in reset while supply is low; read-only state once it rises.
`timescale 1ns/1ps

// ==========================================================================
// synchronous fifo with flush
module sec_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH)
      begin : g_bad_depth
         $error("fifo depth must be a power of two of at least 2");
      end
   endgenerate

   assign in_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
   assign out_valid = (wr_q != rd_q);
   assign out_data = mem[rd_q[AW-1:0]];

   always_ff @(posedge clk)
   begin
      if (in_valid && in_ready)
         mem[wr_q[AW-1:0]] <= in_data;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else if (flush)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else
      begin
         if (in_valid && in_ready)
            wr_q <= wr_q + 1'b1;
         if (out_valid && out_ready)
            rd_q <= rd_q + 1'b1;
      end
   end
endmodule

// ==========================================================================
// top: the memory device behind its serial pins
module sec_engine #(
   parameter int PROG_CYCLES = sec_pkg::PROG_CYCLES_DEF,
   parameter int FIFO_DEPTH = sec_pkg::FIFO_DEPTH_DEF
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic SUPPLY_OK,
   input wire logic WORD_ORG,
   input wire logic CHIP_SELECT,
   input wire logic SERIAL_CLOCK,
   input wire logic SERIAL_IN,
   output logic SERIAL_OUT,
   output logic SERIAL_OUT_OE_N,
   output logic BUSY,
   output logic UNLOCKED
);
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_HEAD = 3'b001,
      ST_DATA = 3'b010,
      ST_ARM = 3'b011,
      ST_READ = 3'b100,
      ST_SKIP = 3'b101,
      ST_BUSY = 3'b110
   } sec_state_t;

   generate
      if (PROG_CYCLES < sec_pkg::WORDS)
      begin : g_bad_prog
         $error("programming time must cover one cycle per word");
      end
   endgenerate

   // word index of a byte or word address
   function automatic logic [sec_pkg::WADDR_W-1:0] word_of(
      input logic [sec_pkg::BADDR_W-1:0] a, input logic x16);
      word_of = x16 ? a[sec_pkg::WADDR_W-1:0] : a[sec_pkg::BADDR_W-1:1];
   endfunction

   sec_state_t state_q;
   logic sk_q;
   logic cs_q;
   logic [3:0] cnt_q;
   logic [sec_pkg::HDR_W-2:0] sh_q;
   logic [sec_pkg::WORD_W-1:0] dsh_q;
   logic unlock_q;
   sec_pkg::sec_prog_t prog_q;
   logic [31:0] busy_cnt_q;
   logic wr_pend_q;
   logic [sec_pkg::WADDR_W-1:0] fill_q;
   logic status_q;
   logic hiz_arm_q;
   logic [sec_pkg::BADDR_W-1:0] rd_addr_q;
   logic [sec_pkg::WORD_W-1:0] osh_q;
   logic [3:0] obits_q;
   logic rd_do_q;
   logic out_q;
   logic oe_n_q;
   logic [sec_pkg::WORD_W-1:0] mem [sec_pkg::WORDS];

   logic sk_rise;
   logic sk_fall;
   logic cs_fall;
   logic x16;
   logic [sec_pkg::HDR_W-1:0] hdr;
   logic [1:0] opc;
   logic [1:0] sel;
   logic [sec_pkg::BADDR_W-1:0] faddr;
   logic [3:0] hdr_last;
   logic [3:0] data_last;
   logic [sec_pkg::WORD_W-1:0] dfull;
   logic fifo_flush;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_pop;
   logic [sec_pkg::WORD_W-1:0] fifo_out;
   logic [sec_pkg::WORD_W-1:0] rd_word;
   logic [sec_pkg::WORD_W-1:0] push_word;
   logic [sec_pkg::WADDR_W-1:0] wr_idx;
   logic [sec_pkg::WORD_W-1:0] wr_word;
   logic all_op;

   assign x16 = WORD_ORG;
   assign sk_rise = SERIAL_CLOCK && !sk_q;
   assign sk_fall = !SERIAL_CLOCK && sk_q;
   assign cs_fall = cs_q && !CHIP_SELECT;
   assign hdr_last = x16 ? sec_pkg::HDR_LAST_X16 : sec_pkg::HDR_LAST_X8;
   assign data_last = x16 ? sec_pkg::DATA_LAST_X16 : sec_pkg::DATA_LAST_X8;

   // ==========================================================================
   // frame field extraction, the top address bit is dropped
   assign hdr = {sh_q, SERIAL_IN};
   assign opc = x16 ? hdr[11:10] : hdr[12:11];
   assign sel = x16 ? hdr[9:8] : hdr[10:9];
   assign faddr = x16 ? {1'b0, hdr[8:0]} : hdr[9:0];
   assign dfull = x16 ? {dsh_q[14:0], SERIAL_IN} : {dsh_q[6:0], SERIAL_IN, 8'h00};

   // ==========================================================================
   // pin sampling
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         sk_q <= 1'b0;
         cs_q <= 1'b0;
      end
      else
      begin
         sk_q <= SERIAL_CLOCK;
         cs_q <= CHIP_SELECT;
      end
   end

   // ==========================================================================
   // command sequencer
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
         sh_q <= '0;
         dsh_q <= '0;
         prog_q <= '0;
         busy_cnt_q <= '0;
      end
      else if (!SUPPLY_OK)
      begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
      end
      else
      begin
         unique case (state_q)
            ST_IDLE:
            begin
               if (CHIP_SELECT && sk_rise && SERIAL_IN)
               begin
                  state_q <= ST_HEAD;
                  cnt_q <= '0;
               end
            end
            ST_HEAD:
            begin
               if (!CHIP_SELECT)
                  state_q <= ST_IDLE;
               else if (sk_rise)
               begin
                  sh_q <= hdr[sec_pkg::HDR_W-2:0];
                  cnt_q <= cnt_q + 4'h1;
                  if (cnt_q == hdr_last)
                  begin
                     cnt_q <= '0;
                     prog_q.addr <= faddr;
                     prog_q.data <= sec_pkg::ERASED_WORD;
                     unique case (opc)
                        sec_pkg::OPC_READ:
                           state_q <= ST_READ;
                        sec_pkg::OPC_WRITE:
                        begin
                           prog_q.op <= sec_pkg::OP_WRITE;
                           state_q <= unlock_q ? ST_DATA : ST_SKIP;
                        end
                        sec_pkg::OPC_ERASE:
                        begin
                           prog_q.op <= sec_pkg::OP_ERASE;
                           state_q <= unlock_q ? ST_ARM : ST_SKIP;
                        end
                        sec_pkg::OPC_SPECIAL:
                        begin
                           prog_q.op <= sec_pkg::OP_CLEAR_ALL;
                           state_q <= ST_SKIP;
                           if (sel == sec_pkg::SEL_FILL_ALL && unlock_q)
                           begin
                              prog_q.op <= sec_pkg::OP_FILL_ALL;
                              state_q <= ST_DATA;
                           end
                           else if (sel == sec_pkg::SEL_CLEAR_ALL && unlock_q)
                              state_q <= ST_ARM;
                        end
                     endcase
                  end
               end
            end
            ST_DATA:
            begin
               if (!CHIP_SELECT)
                  state_q <= ST_IDLE;
               else if (sk_rise)
               begin
                  dsh_q <= {dsh_q[14:0], SERIAL_IN};
                  cnt_q <= cnt_q + 4'h1;
                  if (cnt_q == data_last)
                  begin
                     prog_q.data <= dfull;
                     state_q <= ST_ARM;
                  end
               end
            end
            ST_ARM:
            begin
               // start only if select falls before another rising clock
               if (cs_fall)
               begin
                  state_q <= ST_BUSY;
                  busy_cnt_q <= 32'(PROG_CYCLES - 1);
               end
               else if (sk_rise)
                  state_q <= ST_SKIP;
            end
            ST_READ, ST_SKIP:
            begin
               if (!CHIP_SELECT)
                  state_q <= ST_IDLE;
            end
            ST_BUSY:
            begin
               // serial traffic is not decoded until the cycle ends
               if (busy_cnt_q == '0)
                  state_q <= ST_IDLE;
               else
                  busy_cnt_q <= busy_cnt_q - 32'h1;
            end
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================================
   // write lock, cleared by reset and by low supply
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         unlock_q <= 1'b0;
      else if (!SUPPLY_OK)
         unlock_q <= 1'b0;
      else if (state_q == ST_HEAD && CHIP_SELECT && sk_rise && cnt_q == hdr_last
               && opc == sec_pkg::OPC_SPECIAL)
      begin
         if (sel == sec_pkg::SEL_UNLOCK)
            unlock_q <= 1'b1;
         else if (sel == sec_pkg::SEL_LOCK)
            unlock_q <= 1'b0;
      end
   end

   // ==========================================================================
   // self-timed array update: one location, or every word in turn
   assign all_op = prog_q.op == sec_pkg::OP_CLEAR_ALL || prog_q.op == sec_pkg::OP_FILL_ALL;
   assign wr_idx = all_op ? fill_q : word_of(prog_q.addr, x16);
   assign rd_word = mem[wr_idx];

   always_comb
   begin
      wr_word = prog_q.data;
      if (prog_q.op == sec_pkg::OP_ERASE || prog_q.op == sec_pkg::OP_CLEAR_ALL)
         wr_word = sec_pkg::ERASED_WORD;
      else if (!x16 && prog_q.op == sec_pkg::OP_FILL_ALL)
         wr_word = {prog_q.data[15:8], prog_q.data[15:8]};
      if (!x16 && !all_op)
      begin
         // byte lane replaced outright, so no prior erase is needed
         if (prog_q.addr[0])
            wr_word = {wr_word[15:8], rd_word[7:0]};
         else
            wr_word = {rd_word[15:8], wr_word[15:8]};
      end
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         wr_pend_q <= 1'b0;
         fill_q <= '0;
      end
      else if (state_q == ST_ARM && cs_fall && SUPPLY_OK)
      begin
         wr_pend_q <= 1'b1;
         fill_q <= '0;
      end
      else if (wr_pend_q)
      begin
         fill_q <= fill_q + 1'b1;
         if (!all_op || fill_q == sec_pkg::WADDR_W'(sec_pkg::WORDS - 1))
            wr_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (wr_pend_q)
         mem[wr_idx] <= wr_word;
   end

   // ==========================================================================
   // read prefetch through the fifo, address wraps at the top
   assign fifo_flush = state_q != ST_READ;
   assign push_word = !x16 ? (rd_addr_q[0] ? {mem[word_of(rd_addr_q, x16)][15:8], 8'h00}
                                           : {mem[word_of(rd_addr_q, x16)][7:0], 8'h00})
                           : mem[word_of(rd_addr_q, x16)];

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         rd_addr_q <= '0;
      else if (state_q == ST_HEAD && sk_rise && cnt_q == hdr_last)
         rd_addr_q <= faddr;
      else if (state_q == ST_READ && fifo_in_ready)
      begin
         if (x16)
            rd_addr_q <= {1'b0, rd_addr_q[8:0] + 9'h001};
         else
            rd_addr_q <= rd_addr_q + 10'h001;
      end
   end

   sec_fifo #(
      .WIDTH(sec_pkg::WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(CLK),
      .rst(RST),
      .flush(fifo_flush),
      .in_valid(state_q == ST_READ),
      .in_ready(fifo_in_ready),
      .in_data(push_word),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out)
   );

   // ==========================================================================
   // read shifter: dummy zero once, then words back to back
   assign fifo_pop = state_q == ST_READ && CHIP_SELECT && sk_rise && obits_q == '0
                     && fifo_out_valid;

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         osh_q <= '0;
         obits_q <= '0;
         rd_do_q <= 1'b0;
      end
      else if (state_q == ST_HEAD && sk_rise && cnt_q == hdr_last)
      begin
         rd_do_q <= 1'b0;
         obits_q <= '0;
      end
      else if (state_q == ST_READ && CHIP_SELECT && sk_rise)
      begin
         if (obits_q == '0)
         begin
            rd_do_q <= fifo_out[15];
            osh_q <= {fifo_out[14:0], 1'b0};
            obits_q <= data_last;
         end
         else
         begin
            rd_do_q <= osh_q[15];
            osh_q <= {osh_q[14:0], 1'b0};
            obits_q <= obits_q - 4'h1;
         end
      end
   end

   // ==========================================================================
   // ready/busy reporting and its dummy-one release
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         status_q <= 1'b0;
         hiz_arm_q <= 1'b0;
      end
      else if (!SUPPLY_OK)
      begin
         status_q <= 1'b0;
         hiz_arm_q <= 1'b0;
      end
      else if (state_q == ST_ARM && cs_fall)
      begin
         status_q <= 1'b1;
         hiz_arm_q <= 1'b0;
      end
      else if (status_q && CHIP_SELECT)
      begin
         if (sk_rise && SERIAL_IN)
            hiz_arm_q <= 1'b1;
         else if (sk_fall && hiz_arm_q)
         begin
            status_q <= 1'b0;
            hiz_arm_q <= 1'b0;
         end
      end
      else if (status_q && cs_fall && state_q != ST_BUSY)
         status_q <= 1'b0;
   end

   // ==========================================================================
   // pin drivers
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         out_q <= 1'b0;
         oe_n_q <= 1'b1;
      end
      else if (status_q && CHIP_SELECT)
      begin
         out_q <= state_q != ST_BUSY;
         oe_n_q <= 1'b0;
      end
      else if (state_q == ST_READ && CHIP_SELECT)
      begin
         out_q <= rd_do_q;
         oe_n_q <= 1'b0;
      end
      else
      begin
         out_q <= 1'b0;
         oe_n_q <= 1'b1;
      end
   end

   assign SERIAL_OUT = out_q;
   assign SERIAL_OUT_OE_N = oe_n_q;
   assign BUSY = state_q == ST_BUSY;
   assign UNLOCKED = unlock_q;
endmodule

// >>> dv/sec_engine_chk.sv
// checker: serial pin behaviour of the engine, bound to its top ports
// assumes one clock domain with an active-high asynchronous reset
`timescale 1ns/1ps
module sec_engine_chk #(
   parameter int PROG_CYCLES = 600,
   parameter int FIFO_DEPTH = 16
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic SUPPLY_OK,
   input wire logic WORD_ORG,
   input wire logic CHIP_SELECT,
   input wire logic SERIAL_CLOCK,
   input wire logic SERIAL_IN,
   input wire logic SERIAL_OUT,
   input wire logic SERIAL_OUT_OE_N,
   input wire logic BUSY,
   input wire logic UNLOCKED
);
   int busy_cnt_q;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   // ====
   // length of the self-timed cycle
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         busy_cnt_q <= 0;
      else if (BUSY)
         busy_cnt_q <= busy_cnt_q + 1;
      else
         busy_cnt_q <= 0;
   end
   // ====
   // assertions
   desel_float_a: assert property (!CHIP_SELECT && !$past(CHIP_SELECT) |-> SERIAL_OUT_OE_N)
      else $error("output driven while deselected");
   busy_len_a: assert property ($fell(BUSY) && SUPPLY_OK && $past(SUPPLY_OK)
      |-> busy_cnt_q == PROG_CYCLES)
      else $error("programming cycle length wrong");
   busy_status_a: assert property (BUSY && CHIP_SELECT && !SERIAL_OUT_OE_N |-> !SERIAL_OUT)
      else $error("status not low while busy");
   ready_status_a: assert property ($fell(BUSY) && CHIP_SELECT && $past(CHIP_SELECT, 2)
      |-> ##[1:3] (SERIAL_OUT && !SERIAL_OUT_OE_N))
      else $error("status not high when ready");
   locked_prog_a: assert property ($rose(BUSY) |-> UNLOCKED)
      else $error("programming while locked");
   cs_start_a: assert property ($rose(BUSY)
      |-> !CHIP_SELECT && ($past(CHIP_SELECT) || $past(CHIP_SELECT, 2)))
      else $error("cycle not started by select fall");
   busy_ignore_a: assert property (BUSY && SUPPLY_OK ##1 SUPPLY_OK |-> $stable(UNLOCKED))
      else $error("command taken while busy");
   supply_low_a: assert property (!SUPPLY_OK |=> !UNLOCKED && !BUSY)
      else $error("state kept with supply low");
   out_edge_a: assert property ($changed(SERIAL_OUT) && !SERIAL_OUT_OE_N && !$past(SERIAL_OUT_OE_N)
      && !$past(BUSY) && !$past(BUSY, 2) && !$past(BUSY, 3)
      |-> $past(SERIAL_CLOCK) || $past(SERIAL_CLOCK, 2))
      else $error("read bit moved without clock rise");
   cover property ($rose(BUSY));
   cover property ($fell(SERIAL_OUT_OE_N));
   cover property ($rose(UNLOCKED));
endmodule

bind sec_engine sec_engine_chk #(.PROG_CYCLES(PROG_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) i_chk (
   .CLK(CLK), .RST(RST), .SUPPLY_OK(SUPPLY_OK), .WORD_ORG(WORD_ORG),
   .CHIP_SELECT(CHIP_SELECT), .SERIAL_CLOCK(SERIAL_CLOCK), .SERIAL_IN(SERIAL_IN),
   .SERIAL_OUT(SERIAL_OUT), .SERIAL_OUT_OE_N(SERIAL_OUT_OE_N), .BUSY(BUSY),
   .UNLOCKED(UNLOCKED));

// >>> dv/sec_host.sv
// host model: drives chip select, serial clock and serial data
// assumes tasks are entered just after a falling edge of clk
`timescale 1ns/1ps
module sec_host (
   input wire logic clk,
   input wire logic so,
   output logic cs,
   output logic sk,
   output logic si
);
   initial
   begin
      cs = 1'b0;
      sk = 1'b0;
      si = 1'b0;
   end
   // ====
   // pin tasks
   task automatic hold(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic sel();
      cs = 1'b1;
      hold(3);
   endtask
   // clock stops low and data is turned over once deselected
   task automatic desel();
      sk = 1'b0;
      cs = 1'b0;
      si = ~si;
      hold(4);
   endtask
   task automatic fall();
      sk = 1'b0;
      hold(3);
   endtask
   // msb first; r collects the output at the end of each high phase
   task automatic shift(input int n, input logic [63:0] v, output logic [63:0] r);
      r = '0;
      for (int i = n - 1; i >= 0; i--)
      begin
         sk = 1'b0;
         si = v[i];
         hold(3);
         sk = 1'b1;
         hold(3);
         r = {r[62:0], so};
      end
   endtask
endmodule

// >>> dv/sec_engine_bench.sv
// bench: runs the engine through its serial pins with the host model
// assumes a 50 MHz clock and a shortened programming time
`timescale 1ns/1ps
`define CHK(a, b) \
   begin \
      checks_done++; \
      if ((a) !== (b)) \
      begin \
         n_mismatch++; \
         $display("[ERR] %0t got %h want %h", $time, a, b); \
      end \
   end
module sec_engine_bench;
   logic clk;
   logic rst;
   logic supply_ok;
   logic word_org;
   logic so;
   logic oe_n;
   logic busy;
   logic unlocked;
   logic [63:0] r;
   wire cs, sk, si, line;
   int n_mismatch = 0;
   int checks_done = 0;
   assign line = oe_n ? 1'bz : so;
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   sec_engine #(.PROG_CYCLES(600), .FIFO_DEPTH(16)) i_dut (
      .CLK(clk), .RST(rst), .SUPPLY_OK(supply_ok), .WORD_ORG(word_org),
      .CHIP_SELECT(cs), .SERIAL_CLOCK(sk), .SERIAL_IN(si), .SERIAL_OUT(so),
      .SERIAL_OUT_OE_N(oe_n), .BUSY(busy), .UNLOCKED(unlocked));
   sec_host i_host (.clk(clk), .so(line), .cs(cs), .sk(sk), .si(si));
   // ====
   // tasks
   task automatic end_sim();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic cmd(input int n, input logic [63:0] v);
      i_host.sel();
      i_host.shift(n, v, r);
      i_host.desel();
   endtask
   // programming frame, then status poll and release by a clocked one
   task automatic prog(input int n, input logic [63:0] v);
      cmd(n, v);
      `CHK(busy, 1'b1)
      i_host.sel();
      `CHK({oe_n, so}, 2'b00)
      for (int i = 0; i < 700 && so !== 1'b1; i++)
         i_host.hold(1);
      `CHK({busy, so}, 2'b01)
      i_host.shift(1, 64'h1, r);
      i_host.fall();
      `CHK(oe_n, 1'b1)
      i_host.desel();
   endtask
   // header of n bits, then k clocks of data; dummy zero sits above the data
   task automatic rd(input int n, input logic [63:0] v, input int k, input logic [63:0] e);
      i_host.sel();
      i_host.shift(n + k, v << k, r);
      i_host.desel();
      `CHK(r & ((64'h1 << (k + 1)) - 64'h1), e)
   endtask
   // ====
   // tests
   initial
   begin
      rst = 1'b1;
      supply_ok = 1'b1;
      word_org = 1'b1;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      i_host.hold(2);
      `CHK({unlocked, oe_n}, 2'b01)
      cmd(13, 64'h1200);
      i_host.hold(2);
      `CHK(busy, 1'b0)
      cmd(13, 64'h1300);
      `CHK(unlocked, 1'b1)
      prog(13, 64'h1200);
      rd(13, 64'h1805, 16, 64'hffff);
      prog(29, 64'h15ff1234);
      prog(29, 64'h1400abcd);
      rd(13, 64'h19ff, 32, 64'h1234abcd);
      prog(13, 64'h1c00);
      rd(13, 64'h1800, 16, 64'hffff);
      prog(29, 64'h11005a5a);
      // one clock too many after the data: the write must be dropped
      cmd(30, 64'h2bfe2468);
      i_host.hold(2);
      `CHK(busy, 1'b0)
      cmd(13, 64'h1000);
      `CHK(unlocked, 1'b0)
      cmd(29, 64'h14640000);
      i_host.hold(2);
      `CHK(busy, 1'b0)
      rd(13, 64'h1864, 16, 64'h5a5a);
      cmd(13, 64'h1300);
      supply_ok = 1'b0;
      word_org = 1'b0;
      i_host.hold(3);
      `CHK(unlocked, 1'b0)
      supply_ok = 1'b1;
      i_host.hold(2);
      cmd(14, 64'h2600);
      `CHK(unlocked, 1'b1)
      prog(22, 64'h280377);
      rd(14, 64'h3002, 16, 64'h5a77);
      end_sim();
   end
   initial
   begin
      repeat (40000) @(posedge clk);
      n_mismatch++;
      end_sim();
   end
endmodule
